// ===== verilog/fsgw_cfg.svh
`ifndef FSGW_CFG_SVH
`define FSGW_CFG_SVH
`define FSGW_A_CTRL   6'h00
`define FSGW_A_STAT   6'h04
`define FSGW_A_IRQS   6'h08
`define FSGW_A_IRQM   6'h0c
`define FSGW_A_NODE   6'h10
`define FSGW_A_POUT   6'h14
`define FSGW_A_PIN    6'h18
`define FSGW_A_MBX    6'h1c
`define FSGW_I_CHG    0
`define FSGW_I_REF    1
`define FSGW_I_MIS    2
`define FSGW_I_LAY    3
`define FSGW_I_BAK    4
`define FSGW_I_RST    5
`define FSGW_NIRQ     6
`define FSGW_MAX_SLC  7'h40
`define FSGW_MAX_PTS  13'h0200
`define FSGW_D_IN     6:0
`define FSGW_D_OUT    13:7
`define FSGW_D_EXT    15
`define FSGW_CLK_NS   4
`define FSGW_BLINK_MS 200
`define FSGW_REFR_NS  1000
`define FSGW_LED_LAST 3'h5
`endif

// ===== verilog/fsgw_pkg.sv
package fsgw_pkg;
  typedef enum logic [1:0] {
    init_state, mailbox_only_state, inputs_only_state, op_state
  } fsgw_st_t;
  typedef enum logic [2:0] {
    sc_idle, sc_scan, sc_reg, sc_back, sc_rest
  } fsgw_sc_t;
endpackage : fsgw_pkg

// ===== verilog/fsgw_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fsgw_mem #(
  parameter int W  = 16,
  parameter int AW = 7
) (
  input  wire logic          clk_sys, // System clock
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] addr,    // Shared word address
  input  wire logic [W-1:0]  wdata,   // Write data
  output var  logic [W-1:0]  rdata    // Registered read data
);
  logic [W-1:0] mem_r [2**AW];
  logic [W-1:0] rdata_r;

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
    rdata_r <= mem_r[addr];
  end

  assign rdata = rdata_r;
endmodule : fsgw_mem
`default_nettype wire

// ===== verilog/fsgw_top.sv
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fsgw_cfg.svh"
// Function
// - State changes only when the master writes a state command.
// - Init refuses mailbox traffic and blocks both process-data ways.
// - Mailbox-only state serves mailbox, still blocks process data.
// - Inputs-only state sends inputs, never applies master outputs.
// - Op state serves mailbox, inputs and drives outputs to slices.
// - Lamp off in Init, blinks, single flash, steady on in Op.
// - Up to 64 slices, at most 512 input and 512 output points.
// - Slice configuration is scanned automatically after power-on.
// - Registration switch stores module order and I/O size table.
// - Power-on scan compares against table while the registration switch is on, mismatch raises flag.
// - A slice with extended data layout gives a startup error.
// - Fieldbus and slice refresh run on independent cycles.
// - Backup copies slice parameters; restore writes them back while the registration switch is on.
// - Node address comes from the rotary switches.
// - Outputs flow master to slave, present inputs slave to master.
module fsgw_top import fsgw_pkg::*; #(
  parameter int BLINK_CYC = `FSGW_BLINK_MS * 1000000 / `FSGW_CLK_NS,
  parameter int REFR_CYC  = `FSGW_REFR_NS / `FSGW_CLK_NS
) (
  input  wire logic        clk_sys,         // 250 MHz clock
  input  wire logic        nrst,            // Sync reset, active low
  input  wire logic [5:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  output var  logic [31:0] avs_readdata,    // Read data
  output var  logic        avs_waitrequest, // Stall
  output var  logic        irq,             // Level interrupt
  input  wire logic [7:0]  node_sw,         // Rotary switches
  input  wire logic        sw_reg,          // Table switch
  input  wire logic        sw_back,         // Backup switch
  input  wire logic        sw_rest,         // Restore switch
  input  wire logic [6:0]  slice_cnt,       // Attached slices
  input  wire logic [15:0] slice_desc,      // Selected slice layout
  input  wire logic [15:0] slice_prm,       // Selected slice params
  input  wire logic [31:0] slice_in,        // Slice input points
  output var  logic [5:0]  slice_sel,       // Slice index
  output var  logic        slice_wr,        // Param write strobe
  output var  logic [15:0] slice_wdat,      // Param write data
  output var  logic [31:0] slice_out,       // Slice output points
  output var  logic        led_run          // Operation lamp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  localparam int SW = 82;
  localparam logic [31:0] TICK_LAST = 32'(BLINK_CYC - 1);
  localparam logic [15:0] RF_LAST   = 16'(REFR_CYC - 1);

  function automatic logic legal(fsgw_st_t c, fsgw_st_t n, logic ok);
    logic r;
    r = 1'b0;
    case (n)
      init_state:         r = 1'b1;
      mailbox_only_state: r = 1'b1;
      inputs_only_state:  r = (c != init_state) & ok;
      op_state:           r = ((c == inputs_only_state) | (c == op_state))
                              & ok;
      default:            r = 1'b0;
    endcase
    return r;
  endfunction : legal

  // Pins cross two flops before any logic sees them
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  always_ff @(posedge clk_sys) begin
    s1_r <= {sw_reg, sw_back, sw_rest, node_sw, slice_cnt, slice_desc,
             slice_prm, slice_in};
    s2_r <= s1_r;
  end
  wire        q_reg  = s2_r[81];
  wire        q_back = s2_r[80];
  wire        q_rest = s2_r[79];
  wire [7:0]  q_node = s2_r[78:71];
  wire [6:0]  q_cnt  = s2_r[70:64];
  wire [15:0] q_desc = s2_r[63:48];
  wire [15:0] q_prm  = s2_r[47:32];
  wire [31:0] q_in   = s2_r[31:0];

  fsgw_st_t       st_r;
  fsgw_sc_t       sc_r;
  logic [1:0]     st_q;
  logic           wreq_r;
  logic [31:0]    rdata_r;
  logic [`FSGW_NIRQ-1:0] irqs_r;
  logic [`FSGW_NIRQ-1:0] irqm_r;
  logic           irq_r;
  logic [31:0]    pout_r;
  logic [31:0]    pin_r;
  logic [31:0]    mbx_r;
  logic [31:0]    sout_r;
  logic [15:0]    rf_r;
  logic [31:0]    tick_r;
  logic [2:0]     ph_r;
  logic           led_r;
  logic [2:0]     swd_r;
  logic [6:0]     idx_r;
  logic [1:0]     step_r;
  logic [12:0]    isum_r;
  logic [12:0]    osum_r;
  logic           mis_r;
  logic           lay_r;
  logic           done_r;
  logic           ref_r;
  logic           swr_r;
  logic [15:0]    swd_dat_r;
  logic [15:0]    mem_rd;

  assign st_q = st_r;

  // Avalon slave: one wait cycle, data registered with the drop
  wire acc   = avs_read | avs_write;
  wire take  = !wreq_r & acc;
  wire wr_t  = take & avs_write;
  wire a_ctl = avs_address == `FSGW_A_CTRL;
  wire a_sta = avs_address == `FSGW_A_STAT;
  wire a_irs = avs_address == `FSGW_A_IRQS;
  wire a_irm = avs_address == `FSGW_A_IRQM;
  wire a_nod = avs_address == `FSGW_A_NODE;
  wire a_pou = avs_address == `FSGW_A_POUT;
  wire a_pin = avs_address == `FSGW_A_PIN;
  wire a_mbx = avs_address == `FSGW_A_MBX;

  wire mbx_ok = st_r != init_state;
  wire tx_ok  = (st_r == inputs_only_state) | (st_r == op_state);
  wire rx_ok  = st_r == op_state;
  wire cfg_ok = done_r & !mis_r & !lay_r;

  fsgw_st_t st_req;
  assign st_req = fsgw_st_t'(avs_writedata[1:0]);
  wire cmd_wr = wr_t & a_ctl;
  wire st_acc = legal(st_r, st_req, cfg_ok);
  wire st_chg = cmd_wr & st_acc & (st_req != st_r);
  wire st_ref = cmd_wr & !st_acc;
  wire mbx_rf = wr_t & a_mbx & !mbx_ok;

  wire [31:0] stat_w = {17'h0, q_cnt, ref_r, q_reg, sc_r != sc_idle,
                        lay_r, mis_r, cfg_ok, st_q};
  wire [31:0] rd_mux =
      a_ctl ? {30'h0, st_q} :
      a_sta ? stat_w :
      a_irs ? {26'h0, irqs_r} :
      a_irm ? {26'h0, irqm_r} :
      a_nod ? {24'h0, q_node} :
      a_pou ? pout_r :
      a_pin ? (tx_ok ? pin_r : 32'h0) :
      a_mbx ? (mbx_ok ? mbx_r : 32'h0) : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wreq_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wreq_r <= !(wreq_r & acc);
      if (wreq_r & acc) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r  <= init_state;
      ref_r <= 1'b0;
    end else if (cmd_wr) begin
      st_r  <= st_acc ? st_req : st_r;
      ref_r <= !st_acc;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pout_r <= 32'h0;
      mbx_r  <= 32'h0;
      irqm_r <= '0;
    end else begin
      if (wr_t & a_pou & rx_ok) begin
        pout_r <= avs_writedata;
      end
      if (wr_t & a_mbx & mbx_ok) begin
        mbx_r <= avs_writedata;
      end
      if (wr_t & a_irm) begin
        irqm_r <= avs_writedata[`FSGW_NIRQ-1:0];
      end
    end
  end

  // Slice refresh free-runs, so bus data see a varying extra delay
  wire rf = rf_r == RF_LAST;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rf_r   <= 16'h0;
      pin_r  <= 32'h0;
      sout_r <= 32'h0;
    end else begin
      rf_r <= rf ? 16'h0 : rf_r + 16'h1;
      if (rf) begin
        pin_r <= q_in;
      end
      if (!rx_ok) begin
        sout_r <= 32'h0;
      end else if (rf) begin
        sout_r <= pout_r;
      end
    end
  end

  wire ph_end = ph_r == `FSGW_LED_LAST;
  wire tick   = tick_r == TICK_LAST;
  logic led_nxt;
  assign led_nxt = (st_r == op_state) |
                   ((st_r == mailbox_only_state) & !ph_r[0]) |
                   ((st_r == inputs_only_state) & (ph_r == 3'h0));
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tick_r <= 32'h0;
      ph_r   <= 3'h0;
      led_r  <= 1'b0;
    end else begin
      tick_r <= tick ? 32'h0 : tick_r + 32'h1;
      if (tick) begin
        ph_r <= ph_end ? 3'h0 : ph_r + 3'h1;
      end
      led_r <= led_nxt;
    end
  end

  // Slice sequencer: each index takes four cycles so the synchronised
  // descriptor and the memory read settle before use
  wire [6:0] cnt_c = (q_cnt > `FSGW_MAX_SLC) ? `FSGW_MAX_SLC : q_cnt;
  wire       busy  = sc_r != sc_idle;
  wire       s_end = busy & (step_r == 2'h3);
  wire       fin   = (cnt_c == 7'h0) | (idx_r == cnt_c - 7'h1);
  wire       act   = s_end & (cnt_c != 7'h0);
  wire       chk   = act & (sc_r == sc_scan);
  wire       prm_a = (sc_r == sc_back) | (sc_r == sc_rest);
  wire       m_we  = act & ((sc_r == sc_reg) | (sc_r == sc_back));
  wire [6:0] m_adr = {prm_a, idx_r[5:0]};
  wire [15:0] m_wd = (sc_r == sc_reg) ? q_desc : q_prm;
  wire [2:0] sw_rise = {q_reg, q_back, q_rest} & ~swd_r;
  wire [12:0] isum_n = isum_r + {6'h0, q_desc[`FSGW_D_IN]};
  wire [12:0] osum_n = osum_r + {6'h0, q_desc[`FSGW_D_OUT]};
  wire bad_sz = (isum_n > `FSGW_MAX_PTS) | (osum_n > `FSGW_MAX_PTS) |
                (q_cnt > `FSGW_MAX_SLC);
  wire bad_ly = chk & (q_desc[`FSGW_D_EXT] | bad_sz);
  wire bad_tb = chk & q_reg & (mem_rd != q_desc);

  fsgw_mem #(.W(16), .AW(7)) u_mem (
    .clk_sys (clk_sys),
    .we      (m_we),
    .addr    (m_adr),
    .wdata   (m_wd),
    .rdata   (mem_rd)
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sc_r   <= sc_scan;
      idx_r  <= 7'h0;
      step_r <= 2'h0;
      swd_r  <= 3'h7;
      isum_r <= 13'h0;
      osum_r <= 13'h0;
      mis_r  <= 1'b0;
      lay_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      swd_r  <= {q_reg, q_back, q_rest};
      step_r <= busy ? step_r + 2'h1 : 2'h0;
      if (chk) begin
        isum_r <= isum_n;
        osum_r <= osum_n;
      end
      if (bad_tb) begin
        mis_r <= 1'b1;
      end
      if (bad_ly) begin
        lay_r <= 1'b1;
      end
      case (sc_r)
        sc_idle: begin
          idx_r <= 7'h0;
          if (sw_rise[2]) begin
            sc_r <= sc_reg;
          end else if (sw_rise[1]) begin
            sc_r <= sc_back;
          end else if (sw_rise[0] & q_reg) begin
            sc_r <= sc_rest;
          end
        end
        sc_scan, sc_reg, sc_back, sc_rest: begin
          if (s_end) begin
            idx_r <= idx_r + 7'h1;
            if (fin) begin
              sc_r <= sc_idle;
              if (sc_r == sc_scan) begin
                done_r <= 1'b1;
                lay_r  <= lay_r | bad_ly | (q_cnt > `FSGW_MAX_SLC);
              end
            end
          end
        end
        default: sc_r <= sc_idle;
      endcase
    end
  end

  // Strobe sits in step 2, while slice_sel still names the slot whose
  // saved word is on mem_rd; a later strobe would hit the next slice
  wire rest_w = busy & (sc_r == sc_rest) & (step_r == 2'h1) &
                (cnt_c != 7'h0);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      swr_r     <= 1'b0;
      swd_dat_r <= 16'h0;
    end else begin
      swr_r <= rest_w;
      if (rest_w) begin
        swd_dat_r <= mem_rd;
      end
    end
  end

  wire [`FSGW_NIRQ-1:0] ev;
  assign ev[`FSGW_I_CHG] = st_chg;
  assign ev[`FSGW_I_REF] = st_ref | mbx_rf;
  assign ev[`FSGW_I_MIS] = bad_tb;
  assign ev[`FSGW_I_LAY] = bad_ly;
  assign ev[`FSGW_I_BAK] = s_end & fin & (sc_r == sc_back);
  assign ev[`FSGW_I_RST] = s_end & fin & (sc_r == sc_rest);
  wire [`FSGW_NIRQ-1:0] clr = (wr_t & a_irs) ?
                              avs_writedata[`FSGW_NIRQ-1:0] : '0;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irqs_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      irqs_r <= (irqs_r & ~clr) | ev;
      irq_r  <= |(irqs_r & irqm_r);
    end
  end

  assign avs_waitrequest = wreq_r;
  assign avs_readdata    = rdata_r;
  assign irq             = irq_r;
  assign slice_sel       = idx_r[5:0];
  assign slice_wr        = swr_r;
  assign slice_wdat      = swd_dat_r;
  assign slice_out       = sout_r;
  assign led_run         = led_r;

  sequence cmd_s;
    cmd_wr;
  endsequence
  state_hold_a: assert property (!cmd_wr |=> $stable(st_r))
    else $error("state moved without a command");
  refuse_keep_a: assert property (cmd_s ##0 !st_acc
    |=> $stable(st_r) && irqs_r[`FSGW_I_REF] && ref_r)
    else $error("refused request not held or reported");
  init_mbx_a: assert property (wr_t && a_mbx && st_r == init_state
    |=> $stable(mbx_r) && irqs_r[`FSGW_I_REF])
    else $error("mailbox write taken in init");
  mbx_serve_a: assert property (wr_t && a_mbx && mbx_ok
    |=> mbx_r == $past(avs_writedata))
    else $error("mailbox write lost");
  pin_block_a: assert property (take && avs_read && a_pin
    && !tx_ok |-> rdata_r == 32'h0)
    else $error("inputs leaked before inputs-only state");
  out_gate_a: assert property (st_r != op_state
    |=> sout_r == 32'h0)
    else $error("outputs applied outside op");
  out_apply_a: assert property (rf && rx_ok ##1 rx_ok
    |-> sout_r == $past(pout_r))
    else $error("outputs not refreshed in op");
  lamp_a: assert property (st_r == init_state
    ##1 st_r == init_state |-> !led_r)
    else $error("lamp lit in init");
  ext_err_a: assert property (chk && q_desc[`FSGW_D_EXT]
    |=> lay_r ##[0:300] !cfg_ok)
    else $error("extended layout not flagged");
  mem_write_a: assert property (m_we
    |-> sc_r == sc_reg || sc_r == sc_back)
    else $error("table written outside registration or backup");
  rest_pulse_a: assert property (swr_r
    |-> $stable(slice_sel) && sc_r == sc_rest)
    else $error("restore strobe not aligned to its slot");
endmodule : fsgw_top
`default_nettype wire

// ===== tb/fsgw_slices.sv
`timescale 1ns/1ps
`default_nettype none
module fsgw_slices (
  input  wire logic        clk_sys,    // System clock
  input  wire logic [6:0]  cnt,        // Slices fitted
  input  wire logic [6:0]  bad_idx,    // Slice with extended layout
  input  wire logic        bump,       // Slice 5 fitted with other size
  input  wire logic        swap,       // Replace every module
  input  wire logic [5:0]  slice_sel,  // Index from gateway
  input  wire logic        slice_wr,   // Param write strobe
  input  wire logic [15:0] slice_wdat, // Param write data
  output var  logic [6:0]  slice_cnt,  // Count to gateway
  output var  logic [15:0] slice_desc, // Layout of selected slice
  output var  logic [15:0] slice_prm,  // Params of selected slice
  output var  logic        prm_ok      // All params at original values
);
  logic [15:0] prm_mem [64];
  logic        ext;
  logic [6:0]  in_pts;

  function automatic logic [15:0] prm_of(input logic [5:0] i);
    return {2'h2, i, 8'h5a};
  endfunction : prm_of

  assign slice_cnt = cnt;
  assign ext       = {1'b0, slice_sel} == bad_idx;
  assign in_pts    = (bump && slice_sel == 6'h05) ? 7'h04 : 7'h08;
  // Absent slices answer with a pattern, never with a real descriptor
  assign slice_desc = ({1'b0, slice_sel} >= cnt) ?
                      {~slice_sel, slice_sel, 4'ha} :
                      {ext, 1'b0, 7'h08, in_pts};
  assign slice_prm  = prm_mem[slice_sel];

  initial begin
    for (int i = 0; i < 64; i++) prm_mem[i] = prm_of(i[5:0]);
  end

  always @(posedge clk_sys) begin
    if (swap) begin
      for (int i = 0; i < 64; i++) prm_mem[i] <= ~prm_of(i[5:0]);
    end else if (slice_wr) begin
      prm_mem[slice_sel] <= slice_wdat;
    end
  end

  always_comb begin
    prm_ok = 1'b1;
    for (int i = 0; i < 64; i++) begin
      if (prm_mem[i] !== prm_of(i[5:0])) prm_ok = 1'b0;
    end
  end
endmodule : fsgw_slices
`default_nettype wire

// ===== tb/fsgw_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsgw_cfg.svh"
module fsgw_top_test;
  logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest, irq;
  logic        sw_reg, sw_back, sw_rest, slice_wr, led_run, bump, swap;
  logic        prm_ok;
  logic [5:0]  avs_address, slice_sel;
  logic [6:0]  slice_cnt, cnt, bad_idx;
  logic [7:0]  node_sw;
  logic [15:0] slice_desc, slice_prm, slice_wdat;
  logic [31:0] avs_writedata, avs_readdata, slice_in, slice_out, q, d, c;
  int          num_errors, n_tests, cyc, seed;

  fsgw_top #(.BLINK_CYC(4)) uut (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .node_sw(node_sw), .sw_reg(sw_reg), .sw_back(sw_back),
    .sw_rest(sw_rest), .slice_cnt(slice_cnt), .slice_desc(slice_desc),
    .slice_prm(slice_prm), .slice_in(slice_in), .slice_sel(slice_sel),
    .slice_wr(slice_wr), .slice_wdat(slice_wdat), .slice_out(slice_out),
    .led_run(led_run));
  fsgw_slices chain (.clk_sys(clk_sys), .cnt(cnt), .bad_idx(bad_idx),
    .bump(bump), .swap(swap), .slice_sel(slice_sel), .slice_wr(slice_wr),
    .slice_wdat(slice_wdat), .slice_cnt(slice_cnt),
    .slice_desc(slice_desc), .slice_prm(slice_prm), .prm_ok(prm_ok));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] dw);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= dw;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string nm, input logic [5:0] a,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd_chk

  task automatic wait_idle;
    repeat (5) @(posedge clk_sys);
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, `FSGW_A_STAT, 32'h0);
      if (q[5] === 1'b0) break;
    end
  endtask : wait_idle

  task automatic rst;
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    wait_idle();
  endtask : rst

  function automatic logic [31:0] stat(input logic [1:0] st,
    input logic ok, mis, lay, en, rf);
    return {17'h0, 7'h40, rf, en, 1'b0, lay, mis, ok, st};
  endfunction : stat

  function automatic logic [31:0] led_exp(input int st);
    return (st == 1) ? 32'h18 : (st == 2) ? 32'h08 : 32'h30;
  endfunction : led_exp

  initial begin
    seed = 23312;
    {nrst, avs_read, avs_write, sw_reg, sw_back, sw_rest} = '0;
    {bump, swap, avs_address, avs_writedata} = '0;
    {num_errors, n_tests, cyc} = '0;
    cnt = 7'h40;
    bad_idx = 7'h7f;
    node_sw = $random(seed);
    slice_in = $random(seed);
    rst();
    rd_chk("status", `FSGW_A_STAT, stat(0, 1, 0, 0, 0, 0));
    rd_chk("node", `FSGW_A_NODE, {24'h0, node_sw});
    rd_chk("unmapped", 6'h20, 32'h0);
    chk("led_init", 32'h0, {31'h0, led_run});
    bus(1'b1, `FSGW_A_IRQS, 32'h3f);
    bus(1'b1, `FSGW_A_IRQM, 32'h0);
    $display("test power_on done");
    bus(1'b1, `FSGW_A_MBX, $random(seed));
    rd_chk("mbx_init", `FSGW_A_MBX, 32'h0);
    rd_chk("pin_init", `FSGW_A_PIN, 32'h0);
    bus(1'b1, `FSGW_A_CTRL, 32'h2);
    rd_chk("status_ref", `FSGW_A_STAT, stat(0, 1, 0, 0, 0, 1));
    rd_chk("irqs_ref", `FSGW_A_IRQS, 32'h2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, `FSGW_A_IRQM, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, `FSGW_A_IRQS, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rd_chk("irqs_clr", `FSGW_A_IRQS, 32'h0);
    $display("test init_state done");
    for (int st = 1; st < 4; st++) begin
      slice_in <= $random(seed);
      d = $random(seed);
      // No mapping is ever written, so the detected layout stays in force
      bus(1'b1, `FSGW_A_CTRL, st);
      rd_chk("status_st", `FSGW_A_STAT, stat(st, 1, 0, 0, 0, 0));
      bus(1'b1, `FSGW_A_MBX, d);
      rd_chk("mbx", `FSGW_A_MBX, d);
      bus(1'b1, `FSGW_A_POUT, ~d);
      repeat (300) @(posedge clk_sys);
      rd_chk("pin", `FSGW_A_PIN, (st == 1) ? 32'h0 : slice_in);
      rd_chk("pout", `FSGW_A_POUT, (st == 3) ? ~d : 32'h0);
      chk("slice_out", (st == 3) ? ~d : 32'h0, slice_out);
      c = '0;
      repeat (48) begin
        @(posedge clk_sys);
        c = c + led_run;
      end
      chk("led", led_exp(st), c);
      $display("test state %0d done", st);
    end
    rd_chk("irqs_chg", `FSGW_A_IRQS, 32'h1);
    bus(1'b1, `FSGW_A_CTRL, 32'h0);
    repeat (300) @(posedge clk_sys);
    chk("out_init", 32'h0, slice_out);
    sw_reg <= 1'b1;
    wait_idle();
    rd_chk("status_tab", `FSGW_A_STAT, stat(0, 1, 0, 0, 1, 0));
    bump <= 1'b1;
    rst();
    rd_chk("status_mis", `FSGW_A_STAT, stat(0, 0, 1, 0, 1, 0));
    rd_chk("irqs_mis", `FSGW_A_IRQS, 32'h4);
    bus(1'b1, `FSGW_A_CTRL, 32'h1);
    bus(1'b1, `FSGW_A_CTRL, 32'h2);
    rd_chk("status_mref", `FSGW_A_STAT, stat(1, 0, 1, 0, 1, 1));
    $display("test table done");
    bump    <= 1'b0;
    bad_idx <= 7'h03;
    sw_reg  <= 1'b0;
    rst();
    rd_chk("status_lay", `FSGW_A_STAT, stat(0, 0, 0, 1, 0, 0));
    rd_chk("irqs_lay", `FSGW_A_IRQS, 32'h8);
    bad_idx <= 7'h7f;
    sw_reg  <= 1'b1;
    rst();
    rd_chk("status_ok", `FSGW_A_STAT, stat(0, 1, 0, 0, 1, 0));
    sw_back <= 1'b1;
    wait_idle();
    bus(1'b0, `FSGW_A_IRQS, 32'h0);
    chk("irqs_bak", 32'h1, {31'h0, q[4]});
    swap <= 1'b1;
    @(posedge clk_sys);
    swap <= 1'b0;
    @(posedge clk_sys);
    chk("prm_swap", 32'h0, {31'h0, prm_ok});
    sw_rest <= 1'b1;
    wait_idle();
    bus(1'b0, `FSGW_A_IRQS, 32'h0);
    chk("irqs_rest", 32'h1, {31'h0, q[5]});
    chk("prm_rest", 32'h1, {31'h0, prm_ok});
    $display("test backup done");
    test_done();
  end
endmodule : fsgw_top_test
`default_nettype wire
